// >>> hdl/spirx_event_enables.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps

module spirx_event_enables
   import spirx_pkg::*;
#(
   parameter int unsigned ADR_W = SPIRX_ADR_W
)
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [ADR_W-1:0]     wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 pll_locked_i,
   input  wire spirx_events_s        events_i,
   input  wire spirx_dip4_s          dip4_i,
   input  wire logic [7:0]           fifo_fill_i,
   output logic                      rx_parity_error_ignore_o,
   output logic                      rx_training_detect_enable_o,
   output logic                      rx_baseline_enable_o,
   output logic                      rx_baseline_start_o,
   output logic      [2:0]           rx_parity_align_threshold_o,
   output logic      [7:0]           rx_fifo_high_watermark_o,
   output logic                      rx_fifo_above_watermark_o,
   output logic                      rx_aligned_o,
   output logic                      rx_link_ready_o,
   output logic                      irq_o
);

   // -------------------------------------------------------------------------
   // helper functions
   // -------------------------------------------------------------------------

   // word index of a byte address
   function automatic logic [17:0] word_index(input logic [ADR_W-1:0] adr);
      logic [ADR_W-1:0] shifted;
      shifted = adr >> 2;
      return shifted[17:0];
   endfunction : word_index

   // threshold of zero acts as one word
   function automatic logic [2:0] eff_threshold(input logic [2:0] thr);
      return (thr == 3'h0) ? 3'h1 : thr;
   endfunction : eff_threshold

   // sticky flag update, a new event wins over a clear
   function automatic logic [7:0] sticky(input logic [7:0] flags,
                                         input logic [7:0] clear,
                                         input logic [7:0] set);
      return (flags & ~clear) | set;
   endfunction : sticky

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   spirx_state_s st;
   spirx_state_s next_st;

   logic [17:0] idx;
   logic        req;
   logic        wr_commit;
   logic [7:0]  wr_byte;
   logic [2:0]  threshold;
   logic        unlock_evt;
   logic        align_lost_evt;
   logic        parity_evt;
   logic        training_evt;
   logic [7:0]  bank_raw;
   logic [7:0]  link_raw;
   logic [7:0]  prot_raw;
   logic [7:0]  bank_clr;
   logic [7:0]  link_clr;
   logic [7:0]  prot_clr;

   // -------------------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------------------

   // write lands at the edge where ack is high
   assign idx       = word_index(wb_adr_i);
   assign req       = wb_cyc_i & wb_stb_i;
   assign wr_commit = req & st.ack & wb_we_i & wb_sel_i[0];
   assign wr_byte   = wb_dat_i[7:0];
   assign threshold = eff_threshold(st.ctrl[SPIRX_CTRL_THR_LSB +: 3]);

   // write-one-to-clear strobes for the three flag registers
   assign bank_clr = (wr_commit && idx == SPIRX_IDX_BANKST) ? wr_byte : 8'h00;
   assign link_clr = (wr_commit && idx == SPIRX_IDX_LINKST) ? wr_byte : 8'h00;
   assign prot_clr = (wr_commit && idx == SPIRX_IDX_PROTST) ? wr_byte : 8'h00;

   // -------------------------------------------------------------------------
   // raw events
   // -------------------------------------------------------------------------

   // lock falling edge, seen after the synchroniser
   assign unlock_evt = st.lock_q & ~st.lock_s2;

   // training only recognised while detection is enabled
   assign training_evt = events_i.training_seen & st.ctrl[SPIRX_CTRL_TRAIN];

   // every bad received word is a parity error event
   assign parity_evt = dip4_i.valid & dip4_i.bad;

   // alignment lost when the bad run reaches the threshold while aligned
   assign align_lost_evt = (st.link == SPIRX_RUN) & st.aligned & parity_evt
                         & ((st.bad_cnt + 3'h1) >= threshold);

   // bank events: overrun low nibble, underrun high nibble
   assign bank_raw = {events_i.bank_underrun, events_i.bank_overrun};

   // link events in enable register bit order
   always_comb
   begin
      link_raw                       = 8'h00;
      link_raw[SPIRX_LINK_UNLOCK]    = unlock_evt;
      link_raw[SPIRX_LINK_BASE_DONE] = events_i.baseline_done;
      link_raw[SPIRX_LINK_BASE_FAIL] = events_i.baseline_fail;
      link_raw[SPIRX_LINK_DSK_DONE]  = events_i.deskew_done;
      link_raw[SPIRX_LINK_DSK_FAIL]  = events_i.deskew_fail;
      link_raw[SPIRX_LINK_TRAIN]     = training_evt;
      link_raw[SPIRX_LINK_ALIGN]     = align_lost_evt;
      link_raw[SPIRX_LINK_TXLOF]     = events_i.tx_frame_loss;
   end

   // protocol events in enable register bit order
   always_comb
   begin
      prot_raw                     = 8'h00;
      prot_raw[SPIRX_PROT_BADCTL]  = events_i.bad_control;
      prot_raw[SPIRX_PROT_PARITY]  = parity_evt;
   end

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   always_comb
   begin
      next_st = st;

      // lock synchroniser, first stage read only by the second
      next_st.lock_s1 = pll_locked_i;
      next_st.lock_s2 = st.lock_s1;
      next_st.lock_q  = st.lock_s2;

      // register writes
      if (wr_commit)
      begin
         unique case (idx)
            SPIRX_IDX_CTRL:   next_st.ctrl    = wr_byte;
            SPIRX_IDX_HWM:    next_st.hwm     = wr_byte;
            SPIRX_IDX_BANKEN: next_st.bank_en = wr_byte;
            SPIRX_IDX_LINKEN: next_st.link_en = wr_byte;
            SPIRX_IDX_PROTEN: next_st.prot_en = wr_byte & SPIRX_PROT_MASK;
            default:          next_st.ctrl    = st.ctrl;
         endcase
      end

      // sticky flags, only enabled events set them
      next_st.bank_st = sticky(st.bank_st, bank_clr, bank_raw & st.bank_en);
      next_st.link_st = sticky(st.link_st, link_clr, link_raw & st.link_en);
      next_st.prot_st = sticky(st.prot_st, prot_clr,
                               prot_raw & st.prot_en & SPIRX_PROT_MASK);

      // per-bit gating of link events
      // pll unlock baseline done baseline fail
      // deskew done deskew fail training
      // alignment lost status frame loss gating

      // interrupt from enabled sticky flags
      next_st.irq = |(next_st.bank_st & next_st.bank_en)
                  | |(next_st.link_st & next_st.link_en)
                  | |(next_st.prot_st & next_st.prot_en);

      // link sequencer: lock, then baseline, then normal reception
      unique case (st.link)
         SPIRX_WAIT_LOCK:
         begin
            if (st.lock_s2)
            begin
               if (st.ctrl[SPIRX_CTRL_BASELINE])
                  next_st.link = SPIRX_BASELINE;
               else
                  next_st.link = SPIRX_RUN;
            end
         end
         SPIRX_BASELINE:
         begin
            if (!st.ctrl[SPIRX_CTRL_BASELINE])
               next_st.link = SPIRX_RUN;
            else if (events_i.baseline_fail)
               next_st.link = SPIRX_FAILED;
            else if (events_i.baseline_done)
               next_st.link = SPIRX_RUN;
         end
         SPIRX_RUN:
         begin
            next_st.link = SPIRX_RUN;
         end
         SPIRX_FAILED:
         begin
            next_st.link = SPIRX_FAILED;
         end
      endcase

      // lost lock restarts the sequence from any state
      if (!st.lock_s2)
         next_st.link = SPIRX_WAIT_LOCK;

      // alignment tracker from consecutive parity results
      if (st.link != SPIRX_RUN)
      begin
         next_st.aligned  = 1'b0;
         next_st.bad_cnt  = SPIRX_RST_CNT;
         next_st.good_cnt = SPIRX_RST_CNT;
      end
      else if (dip4_i.valid)
      begin
         if (dip4_i.bad)
         begin
            next_st.good_cnt = SPIRX_RST_CNT;
            if (align_lost_evt)
            begin
               next_st.aligned = 1'b0;
               next_st.bad_cnt = SPIRX_RST_CNT;
            end
            else if (st.aligned)
               next_st.bad_cnt = st.bad_cnt + 3'h1;
         end
         else
         begin
            next_st.bad_cnt = SPIRX_RST_CNT;
            if (!st.aligned)
            begin
               if ((st.good_cnt + 3'h1) >= threshold)
               begin
                  next_st.aligned  = 1'b1;
                  next_st.good_cnt = SPIRX_RST_CNT;
               end
               else
                  next_st.good_cnt = st.good_cnt + 3'h1;
            end
         end
      end

      // ready keeps passing data when parity errors are ignored
      next_st.ready = (next_st.link == SPIRX_RUN)
                    & (next_st.aligned | next_st.ctrl[SPIRX_CTRL_IGNORE]);

      // fifo fill above the programmed watermark
      next_st.fifo_high = (fifo_fill_i > st.hwm);

      // single-cycle acknowledge with registered read data
      next_st.ack   = req & ~st.ack;
      next_st.rdata = 8'h00;
      if (req && !st.ack && !wb_we_i)
      begin
         unique case (idx)
            SPIRX_IDX_CTRL:   next_st.rdata = st.ctrl;
            SPIRX_IDX_HWM:    next_st.rdata = st.hwm;
            SPIRX_IDX_BANKEN: next_st.rdata = st.bank_en;
            SPIRX_IDX_LINKEN: next_st.rdata = st.link_en;
            SPIRX_IDX_PROTEN: next_st.rdata = st.prot_en;
            SPIRX_IDX_BANKST: next_st.rdata = st.bank_st;
            SPIRX_IDX_LINKST: next_st.rdata = st.link_st;
            SPIRX_IDX_PROTST: next_st.rdata = st.prot_st;
            default:          next_st.rdata = 8'h00;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st          <= '0;
         st.ctrl     <= SPIRX_RST_REG;
         st.hwm      <= SPIRX_RST_REG;
         st.bank_en  <= SPIRX_RST_REG;
         st.link_en  <= SPIRX_RST_REG;
         st.prot_en  <= SPIRX_RST_REG;
         st.bank_st  <= SPIRX_RST_REG;
         st.link_st  <= SPIRX_RST_REG;
         st.prot_st  <= SPIRX_RST_REG;
         st.link     <= SPIRX_WAIT_LOCK;
         st.bad_cnt  <= SPIRX_RST_CNT;
         st.good_cnt <= SPIRX_RST_CNT;
         st.rdata    <= SPIRX_RST_REG;
      end
      else
      begin
         st <= next_st;
      end
   end

   // -------------------------------------------------------------------------
   // outputs, all from the state register
   // -------------------------------------------------------------------------
   assign wb_dat_o                    = {24'h00_0000, st.rdata};
   assign wb_ack_o                    = st.ack;
   assign rx_parity_error_ignore_o    = st.ctrl[SPIRX_CTRL_IGNORE];
   assign rx_training_detect_enable_o = st.ctrl[SPIRX_CTRL_TRAIN];
   assign rx_baseline_enable_o        = st.ctrl[SPIRX_CTRL_BASELINE];
   assign rx_baseline_start_o         = (st.link == SPIRX_BASELINE);
   assign rx_parity_align_threshold_o = st.ctrl[SPIRX_CTRL_THR_LSB +: 3];
   assign rx_fifo_high_watermark_o    = st.hwm;
   assign rx_fifo_above_watermark_o   = st.fifo_high;
   assign rx_aligned_o                = st.aligned;
   assign rx_link_ready_o             = st.ready;
   assign irq_o                       = st.irq;

endmodule : spirx_event_enables

// >>> hdl/spirx_pkg.sv
package spirx_pkg;

   // ----------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam int unsigned SPIRX_IDX_W      = 18;
   localparam int unsigned SPIRX_ADR_W      = 20;
   localparam logic [17:0] SPIRX_IDX_CTRL   = 18'h3_0910;
   localparam logic [17:0] SPIRX_IDX_HWM    = 18'h3_0911;
   localparam logic [17:0] SPIRX_IDX_BANKEN = 18'h3_0912;
   localparam logic [17:0] SPIRX_IDX_LINKEN = 18'h3_0913;
   localparam logic [17:0] SPIRX_IDX_PROTEN = 18'h3_0914;
   localparam logic [17:0] SPIRX_IDX_BANKST = 18'h3_0918;
   localparam logic [17:0] SPIRX_IDX_LINKST = 18'h3_0919;
   localparam logic [17:0] SPIRX_IDX_PROTST = 18'h3_091A;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int unsigned SPIRX_CTRL_THR_LSB   = 1;
   localparam int unsigned SPIRX_CTRL_IGNORE    = 5;
   localparam int unsigned SPIRX_CTRL_TRAIN     = 6;
   localparam int unsigned SPIRX_CTRL_BASELINE  = 7;
   localparam int unsigned SPIRX_LINK_UNLOCK    = 0;
   localparam int unsigned SPIRX_LINK_BASE_DONE = 1;
   localparam int unsigned SPIRX_LINK_BASE_FAIL = 2;
   localparam int unsigned SPIRX_LINK_DSK_DONE  = 3;
   localparam int unsigned SPIRX_LINK_DSK_FAIL  = 4;
   localparam int unsigned SPIRX_LINK_TRAIN     = 5;
   localparam int unsigned SPIRX_LINK_ALIGN     = 6;
   localparam int unsigned SPIRX_LINK_TXLOF     = 7;
   localparam int unsigned SPIRX_PROT_BADCTL    = 1;
   localparam int unsigned SPIRX_PROT_PARITY    = 5;
   localparam logic [7:0]  SPIRX_PROT_MASK      = 8'h22;

   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0]  SPIRX_RST_REG        = 8'h00;
   localparam logic [2:0]  SPIRX_RST_CNT        = 3'h0;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SPIRX_WAIT_LOCK = 2'b00,
      SPIRX_BASELINE  = 2'b01,
      SPIRX_RUN       = 2'b10,
      SPIRX_FAILED    = 2'b11
   } spirx_link_e;

   // one-cycle event strobes from the receive core
   typedef struct packed {
      logic [3:0] bank_overrun;
      logic [3:0] bank_underrun;
      logic       baseline_done;
      logic       baseline_fail;
      logic       deskew_done;
      logic       deskew_fail;
      logic       training_seen;
      logic       tx_frame_loss;
      logic       bad_control;
   } spirx_events_s;

   // parity check result of one received word
   typedef struct packed {
      logic valid;
      logic bad;
   } spirx_dip4_s;

   // complete state of the block
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  hwm;
      logic [7:0]  bank_en;
      logic [7:0]  link_en;
      logic [7:0]  prot_en;
      logic [7:0]  bank_st;
      logic [7:0]  link_st;
      logic [7:0]  prot_st;
      spirx_link_e link;
      logic        lock_s1;
      logic        lock_s2;
      logic        lock_q;
      logic        aligned;
      logic [2:0]  bad_cnt;
      logic [2:0]  good_cnt;
      logic        fifo_high;
      logic        ready;
      logic        ack;
      logic [7:0]  rdata;
      logic        irq;
   } spirx_state_s;

endpackage : spirx_pkg

// >>> sim/spirx_event_enables_sva.sv
`timescale 1ns/1ps
module spirx_event_enables_sva
   import spirx_pkg::*;
#(
   parameter int unsigned ADR_W = SPIRX_ADR_W
)
(
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic             pll_locked_i,
   input wire spirx_events_s    events_i,
   input wire spirx_dip4_s      dip4_i,
   input wire logic [7:0]       fifo_fill_i,
   input wire logic             rx_parity_error_ignore_o,
   input wire logic             rx_training_detect_enable_o,
   input wire logic             rx_baseline_enable_o,
   input wire logic             rx_baseline_start_o,
   input wire logic [2:0]       rx_parity_align_threshold_o,
   input wire logic [7:0]       rx_fifo_high_watermark_o,
   input wire logic             rx_fifo_above_watermark_o,
   input wire logic             rx_aligned_o,
   input wire logic             rx_link_ready_o,
   input wire logic             irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------------
   // register bus handshake and reset values
   // ----------------------------------------------------------------------
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   rdata_idle_a: assert property (!wb_ack_o || wb_dat_o[31:8] == 24'h00_0000 |->
      (wb_ack_o || wb_dat_o == 32'h0000_0000)) else $error("read data outside ack");
   reset_quiet_a: assert property ($fell(rst_i) |-> !irq_o && !rx_baseline_start_o
      && rx_fifo_high_watermark_o == 8'h00) else $error("outputs not cleared by reset");
   // ----------------------------------------------------------------------
   // watermark, sequencer and interrupt
   // ----------------------------------------------------------------------
   wm_compare_a: assert property (!$past(rst_i) |-> rx_fifo_above_watermark_o ==
      ($past(fifo_fill_i) > $past(rx_fifo_high_watermark_o))) else $error("watermark compare");
   base_gate_a: assert property ($rose(rx_baseline_start_o) |-> rx_baseline_enable_o)
      else $error("baseline started while disabled");
   base_lock_a: assert property ($rose(rx_baseline_start_o) |-> $past(pll_locked_i, 3))
      else $error("baseline started without lock");
   unlock_idle_a: assert property (!pll_locked_i [*5] |-> !rx_baseline_start_o
      && !rx_link_ready_o) else $error("link active without lock");
   ready_ignore_a: assert property (rx_link_ready_o && !rx_aligned_o && !$past(rx_aligned_o)
      |-> rx_parity_error_ignore_o || $past(rx_parity_error_ignore_o)) else $error("ready unaligned");
   irq_cause_a: assert property ($rose(irq_o) |-> $past(|events_i) || $past(dip4_i.valid)
      || $past(dip4_i.valid, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2)
      || !$past(pll_locked_i, 3) || !$past(pll_locked_i, 4)) else $error("irq without cause");
   ack_c: cover property (wb_ack_o && wb_we_i);
   irq_c: cover property ($rose(irq_o));
   base_c: cover property ($fell(rx_baseline_start_o));
   align_c: cover property ($fell(rx_aligned_o));
endmodule : spirx_event_enables_sva

bind spirx_event_enables spirx_event_enables_sva #(.ADR_W(ADR_W)) spirx_event_enables_sva_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .pll_locked_i(pll_locked_i), .events_i(events_i), .dip4_i(dip4_i),
   .fifo_fill_i(fifo_fill_i), .rx_parity_error_ignore_o(rx_parity_error_ignore_o),
   .rx_training_detect_enable_o(rx_training_detect_enable_o),
   .rx_baseline_enable_o(rx_baseline_enable_o), .rx_baseline_start_o(rx_baseline_start_o),
   .rx_parity_align_threshold_o(rx_parity_align_threshold_o),
   .rx_fifo_high_watermark_o(rx_fifo_high_watermark_o),
   .rx_fifo_above_watermark_o(rx_fifo_above_watermark_o), .rx_aligned_o(rx_aligned_o),
   .rx_link_ready_o(rx_link_ready_o), .irq_o(irq_o));

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   import spirx_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, lock, ack, ign, trn, ben, bst, abv, alg, rdy, irq;
   logic [19:0] adr;
   logic [3:0]  sel;
   logic [31:0] dw, dr;
   logic [14:0] ev;
   logic [1:0]  dip;
   logic [7:0]  fill, wm;
   logic [2:0]  thr;
   int          n_mismatch, compares;
   // ----------------------------------------------------------------------
   // device and clock
   // ----------------------------------------------------------------------
   spirx_event_enables spirx_event_enables_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
      .wb_dat_o(dr), .wb_ack_o(ack), .pll_locked_i(lock), .events_i(ev), .dip4_i(dip),
      .fifo_fill_i(fill), .rx_parity_error_ignore_o(ign), .rx_training_detect_enable_o(trn),
      .rx_baseline_enable_o(ben), .rx_baseline_start_o(bst), .rx_parity_align_threshold_o(thr),
      .rx_fifo_high_watermark_o(wm), .rx_fifo_above_watermark_o(abv), .rx_aligned_o(alg),
      .rx_link_ready_o(rdy), .irq_o(irq));
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [17:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
      int n;
      @(posedge clk_i);
      {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'hf};
      adr <= {idx, 2'b00};
      dw <= {24'h00_0000, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50)
         chk(32'h0000_0000, 32'h0000_0001);
      q = dr[7:0];
      {cyc, stb} <= 2'b00;
   endtask : wb
   task automatic wr(input logic [17:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
   endtask : wr
   task automatic rc(input logic [17:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk({24'h00_0000, q}, {24'h00_0000, exp});
   endtask : rc
   // one-cycle event strobe, returns at the edge that takes it
   task automatic pulse(input logic [14:0] e, input logic [1:0] d);
      @(posedge clk_i);
      ev <= e;
      dip <= d;
      @(posedge clk_i);
      ev <= 15'h0000;
      dip <= 2'b00;
      #1;
   endtask : pulse
   task automatic evt(input logic [17:0] en, input logic [17:0] st, input int b,
                      input logic [14:0] e, input logic [1:0] d);
      wr(en, 8'h00);
      pulse(e, d);
      rc(st, 8'h00);
      chk(irq, 1'b0);
      wr(en, 8'(1 << b));
      pulse(e, d);
      chk(irq, 1'b1);
      rc(st, 8'(1 << b));
      wr(st, 8'(1 << b));
      rc(st, 8'h00);
      chk(irq, 1'b0);
   endtask : evt
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic t_regs();
      logic [17:0] r[5];
      r = '{SPIRX_IDX_CTRL, SPIRX_IDX_HWM, SPIRX_IDX_BANKEN, SPIRX_IDX_LINKEN, SPIRX_IDX_PROTEN};
      foreach (r[i]) rc(r[i], 8'h00);
      wr(SPIRX_IDX_CTRL, 8'hee);
      rc(SPIRX_IDX_CTRL, 8'hee);
      chk({ign, trn, ben, thr}, 6'h3f);
      wr(SPIRX_IDX_CTRL, 8'h12);
      rc(SPIRX_IDX_CTRL, 8'h12);
      chk({ign, trn, ben, thr}, 6'h01);
      wr(SPIRX_IDX_PROTEN, 8'hff);
      rc(SPIRX_IDX_PROTEN, 8'h22);
      wr(SPIRX_IDX_BANKEN, 8'ha5);
      rc(SPIRX_IDX_BANKEN, 8'ha5);
      wr(SPIRX_IDX_LINKEN, 8'h5a);
      rc(SPIRX_IDX_LINKEN, 8'h5a);
      rc(18'h3_0915, 8'h00);
   endtask : t_regs
   task automatic t_watermark();
      wr(SPIRX_IDX_HWM, 8'h40);
      fill <= 8'h41;
      repeat (3) @(posedge clk_i);
      chk({wm, abv}, {8'h40, 1'b1});
      fill <= 8'h40;
      repeat (3) @(posedge clk_i);
      chk(abv, 1'b0);
   endtask : t_watermark
   task automatic t_events();
      int lb[6] = '{1, 2, 3, 4, 5, 7};
      int eb[6] = '{6, 5, 4, 3, 2, 1};
      wr(SPIRX_IDX_CTRL, 8'h40);
      for (int i = 0; i < 8; i++)
         evt(SPIRX_IDX_BANKEN, SPIRX_IDX_BANKST, i, 15'(1) << (i < 4 ? 11 + i : 3 + i), 2'b00);
      foreach (lb[i])
         evt(SPIRX_IDX_LINKEN, SPIRX_IDX_LINKST, lb[i], 15'(1) << eb[i], 2'b00);
      evt(SPIRX_IDX_PROTEN, SPIRX_IDX_PROTST, 1, 15'h0001, 2'b00);
      evt(SPIRX_IDX_PROTEN, SPIRX_IDX_PROTST, 5, 15'h0000, 2'b11);
      wr(SPIRX_IDX_CTRL, 8'h00);
      wr(SPIRX_IDX_LINKEN, 8'h20);
      pulse(15'h0004, 2'b00);
      rc(SPIRX_IDX_LINKST, 8'h00);
   endtask : t_events
   task automatic t_link();
      int n;
      wr(SPIRX_IDX_LINKEN, 8'hff);
      wr(SPIRX_IDX_PROTEN, 8'h22);
      wr(SPIRX_IDX_CTRL, 8'hc4);
      lock <= 1'b1;
      for (n = 0; n < 20 && bst !== 1'b1; n++) @(posedge clk_i);
      chk(bst, 1'b1);
      pulse(15'h0040, 2'b00);
      repeat (2) @(posedge clk_i);
      chk({bst, rdy}, 2'b00);
      repeat (2) pulse(15'h0000, 2'b10);
      repeat (2) @(posedge clk_i);
      chk({alg, rdy}, 2'b11);
      pulse(15'h0000, 2'b11);
      repeat (2) @(posedge clk_i);
      chk(alg, 1'b1);
      pulse(15'h0000, 2'b11);
      repeat (2) @(posedge clk_i);
      chk({alg, rdy}, 2'b00);
      wr(SPIRX_IDX_CTRL, 8'he4);
      repeat (2) @(posedge clk_i);
      chk(rdy, 1'b1);
      rc(SPIRX_IDX_PROTST, 8'h20);
      lock <= 1'b0;
      repeat (8) @(posedge clk_i);
      rc(SPIRX_IDX_LINKST, 8'h43);
      wr(SPIRX_IDX_CTRL, 8'h64);
      lock <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk({bst, rdy}, 2'b01);
   endtask : t_link
   // ----------------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------------
   task automatic report_and_stop();
      if (n_mismatch == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   initial
   begin
      {rst_i, cyc, stb, we, lock, sel, adr, dw, ev, dip, fill} = {1'b1, 85'h0};
      n_mismatch = 0;
      compares = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_watermark();
      t_events();
      t_link();
      report_and_stop();
   end
   // hang guard, far beyond the few hundred cycles needed
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      report_and_stop();
   end
endmodule : testbench
